// ===== core/cpsq_params.svh
`ifndef CPSQ_PARAMS_SVH
`define CPSQ_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CPSQ_ADDR_CTRL    4'h0
`define CPSQ_ADDR_LIMIT   4'h4
`define CPSQ_ADDR_STATUS  4'h8
`define CPSQ_ADDR_WDOG    4'hC

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CPSQ_CTRL_CHG_EN    0
`define CPSQ_CTRL_LL_DIS    1
`define CPSQ_CTRL_REV_EN    2
`define CPSQ_CTRL_REV_LIM   3
`define CPSQ_CTRL_DET_REQ   4
`define CPSQ_CTRL_BSW_OFF   5
`define CPSQ_CTRL_BSW_RSTEN 6
`define CPSQ_CTRL_BSW_DLY   7
`define CPSQ_CTRL_RST       8'h40

// ----------------------------------------
// limit register fields and reset values
// ----------------------------------------
`define CPSQ_ICL_RST      5'h0_4
`define CPSQ_ICL_500      5'h0_4
`define CPSQ_ICL_2400     5'h1_7
`define CPSQ_ICL_200      5'h0_1
`define CPSQ_VIL_RST      4'h6
`define CPSQ_TRK_RST      2'h0
`define CPSQ_SRC_NONE     3'h0
`define CPSQ_SRC_USB      3'h1
`define CPSQ_SRC_ADAPT    3'h2
`define CPSQ_SRC_REV      3'h7
`define CPSQ_WDSEL_RST    2'h1

// ----------------------------------------
// timing, clock 20 MHz, times in ms
// ----------------------------------------
`define CPSQ_CLK_KHZ      20000
`define CPSQ_T_BIAS_MS    220
`define CPSQ_T_QUAL_MS    30
`define CPSQ_T_RETRY_MS   2000
`define CPSQ_T_REV_MS     30
`define CPSQ_T_SAFE_MS    21600000
`define CPSQ_T_WD1_MS     40000
`define CPSQ_T_WD2_MS     80000
`define CPSQ_T_WD3_MS     160000
`define CPSQ_MS_CYC       (`CPSQ_CLK_KHZ)
`define CPSQ_PULSE_CYC    16

`endif

// ===== core/cpsq_pkg.sv
package cpsq_pkg;

	typedef enum logic [6:0] {
		ST_OFF   = 7'b000_0001,
		ST_BIAS  = 7'b000_0010,
		ST_QUAL  = 7'b000_0100,
		ST_WAIT  = 7'b000_1000,
		ST_DET   = 7'b001_0000,
		ST_CONV  = 7'b010_0000,
		ST_REV   = 7'b100_0000
	} cpsq_state_t;

	typedef logic [31:0] cpsq_word_t;

endpackage

// ===== core/cpsq_seq.sv
// Summary of operation
// - battery only: switch on, bias regulator off
// - overload in supplement: switch off, flag set
// - switch stays off until input or exit
// - bias, qualify, detect, voltage limit, converter
// - bias on after 220ms input present
// - qualify over 30ms window under load
// - failed qualification retries every two seconds
// - qualified: input good flag, event pulse
// - detection done: limit, power good, type, pulse
// - select high 500mA/001, low 2400mA/010
// - default mode tracks pin; host requests update
// - tracking offset raises voltage limit floor
// - converter waits for limit; 200mA below 2.2V
// - after start switch follows charge enable
// - light load only when allowed and enabled
// - reverse supply after 30ms and conditions
// - reverse: status 111, current limit, light start
// - reset: default mode, expired flag high
// - default mode six hour charge limit
// - kick enters host mode, restarts watchdog
// - expiry resets registers except kept fields
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "cpsq_params.svh"

module cpsq_seq
	import cpsq_pkg::*;
#(
	parameter int unsigned BIAS_CYC  = `CPSQ_T_BIAS_MS * `CPSQ_MS_CYC,
	parameter int unsigned QUAL_CYC  = `CPSQ_T_QUAL_MS * `CPSQ_MS_CYC,
	parameter int unsigned RETRY_CYC = `CPSQ_T_RETRY_MS * `CPSQ_MS_CYC,
	parameter int unsigned REV_CYC   = `CPSQ_T_REV_MS * `CPSQ_MS_CYC,
	parameter int unsigned MS_CYC    = `CPSQ_MS_CYC,
	parameter int unsigned SAFE_MS   = `CPSQ_T_SAFE_MS,
	parameter int unsigned WD1_MS    = `CPSQ_T_WD1_MS
) (
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	// wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// analog comparator inputs
	input  wire logic        BAT_ABOVE_DEPLETION,
	input  wire logic        BAT_OVERCURRENT,
	input  wire logic        SHIP_EXIT,
	input  wire logic        INPUT_PRESENT,
	input  wire logic        INPUT_ABOVE_SLEEP,
	input  wire logic        INPUT_BELOW_OV,
	input  wire logic        INPUT_ABOVE_MIN,
	input  wire logic        SOURCE_SELECT,
	input  wire logic        SYS_BELOW_2V2,
	input  wire logic        BAT_BELOW_MINSYS,
	input  wire logic        BAT_ABOVE_LOW,
	input  wire logic        INPUT_BELOW_BAT_SLEEP,
	input  wire logic        THERMISTOR_INPUT_OK,
	input  wire logic        BAT_ABOVE_VIL,
	// power stage controls
	output logic             BATTERY_SWITCH_ON,
	output logic             INTERNAL_BIAS_REGULATOR,
	output logic             QUAL_LOAD_ON,
	output logic             CONVERTER_ON,
	output logic             REVERSE_MODE,
	output logic             REVERSE_LIMIT_HIGH,
	output logic             LIGHT_LOAD_ALLOW,
	output logic             CHARGE_ACTIVE,
	output logic             USE_TRACKED_VLIMIT,
	output logic [4:0]       EFFECTIVE_ICL,
	output logic             HOST_EVENT_PULSE_N
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	cpsq_state_t st_q;
	logic [31:0] cnt_q;
	logic [31:0] wd_cyc_q;
	logic [31:0] wd_ms_q;
	logic [31:0] safe_cyc_q;
	logic [31:0] safe_ms_q;
	logic [31:0] rev_cnt_q;
	logic [4:0]  pulse_q;
	logic        chg_en_q, ll_dis_q, rev_en_q, rev_lim_q, det_req_q;
	logic        bsw_off_q, bsw_rsten_q, bsw_dly_q;
	logic [4:0]  icl_q;
	logic [3:0]  vil_q;
	logic [1:0]  trk_q;
	logic [1:0]  wdsel_q;
	logic        host_q, wd_exp_q, in_good_q, pg_q, safe_done_q;
	logic [2:0]  src_q;

	logic bus_wr, bus_rd, kick, wd_expire, event_d, ok_bias, rev_go;
	assign bus_wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O
		&& WB_SEL_I[0];
	assign bus_rd = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
	assign kick = bus_wr && WB_ADR_I == `CPSQ_ADDR_WDOG && WB_DAT_I[0];
	assign ok_bias = INPUT_PRESENT && INPUT_ABOVE_SLEEP;
	assign rev_go = rev_en_q && rev_cnt_q >= REV_CYC && BAT_ABOVE_LOW
		&& INPUT_BELOW_BAT_SLEEP && THERMISTOR_INPUT_OK;

	function automatic logic [31:0] wd_limit(input logic [1:0] s);
		case (s)
			2'h1: wd_limit = WD1_MS;
			2'h2: wd_limit = `CPSQ_T_WD2_MS;
			default: wd_limit = `CPSQ_T_WD3_MS;
		endcase
	endfunction

	function automatic logic [4:0] pin_icl(input logic sel);
		pin_icl = sel ? `CPSQ_ICL_500 : `CPSQ_ICL_2400;
	endfunction

	function automatic logic [2:0] pin_src(input logic sel);
		pin_src = sel ? `CPSQ_SRC_USB : `CPSQ_SRC_ADAPT;
	endfunction

	assign wd_expire = host_q && wdsel_q != 2'h0
		&& wd_ms_q >= wd_limit(wdsel_q);

	// ----------------------------------------
	// power-up sequencer
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		event_d <= 1'b0;
		if (RESET) begin
			st_q <= ST_OFF;
			cnt_q <= 32'h0000_0000;
			in_good_q <= 1'b0;
			pg_q <= 1'b0;
			src_q <= `CPSQ_SRC_NONE;
		end else if (!ok_bias && st_q != ST_REV) begin
			// reverse supply starts from the input-off state only
			if (st_q == ST_OFF && rev_go) begin
				st_q <= ST_REV;
			end else begin
				st_q <= ST_OFF;
			end
			cnt_q <= 32'h0000_0000;
			in_good_q <= 1'b0;
			pg_q <= 1'b0;
			src_q <= `CPSQ_SRC_NONE;
		end else begin
			case (st_q)
				ST_OFF: begin
					if (rev_go) begin
						st_q <= ST_REV;
					end else if (cnt_q >= BIAS_CYC - 1) begin
						st_q <= ST_BIAS;
						cnt_q <= 32'h0000_0000;
					end else begin
						cnt_q <= cnt_q + 32'h0000_0001;
					end
				end
				ST_BIAS: begin
					st_q <= ST_QUAL;
				end
				ST_QUAL: begin
					if (!(INPUT_BELOW_OV && INPUT_ABOVE_MIN)) begin
						st_q <= ST_WAIT;
						cnt_q <= 32'h0000_0000;
					end else if (cnt_q >= QUAL_CYC - 1) begin
						st_q <= ST_DET;
						in_good_q <= 1'b1;
						event_d <= 1'b1;
						cnt_q <= 32'h0000_0000;
					end else begin
						cnt_q <= cnt_q + 32'h0000_0001;
					end
				end
				ST_WAIT: begin
					if (cnt_q >= RETRY_CYC - 1) begin
						st_q <= ST_QUAL;
						cnt_q <= 32'h0000_0000;
					end else begin
						cnt_q <= cnt_q + 32'h0000_0001;
					end
				end
				ST_DET: begin
					// let the qualification pulse end so two pulses show
					if (!event_d && pulse_q == 5'h0_0 && HOST_EVENT_PULSE_N) begin
						st_q <= ST_CONV;
						pg_q <= 1'b1;
						src_q <= pin_src(SOURCE_SELECT);
						event_d <= 1'b1;
					end
				end
				ST_CONV: begin
					st_q <= ST_CONV;
				end
				ST_REV: begin
					src_q <= `CPSQ_SRC_REV;
					if (!rev_en_q || !BAT_ABOVE_LOW || !THERMISTOR_INPUT_OK) begin
						st_q <= ST_OFF;
						src_q <= `CPSQ_SRC_NONE;
					end
				end
				default: st_q <= ST_OFF;
			endcase
		end
	end

	// reverse enable settle counter
	always_ff @(posedge CLOCK) begin
		if (RESET || !rev_en_q) begin
			rev_cnt_q <= 32'h0000_0000;
		end else if (rev_cnt_q < REV_CYC) begin
			rev_cnt_q <= rev_cnt_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// event pulse
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			pulse_q <= 5'h0_0;
		end else if (event_d) begin
			pulse_q <= 5'(`CPSQ_PULSE_CYC);
		end else if (pulse_q != 5'h0_0) begin
			pulse_q <= pulse_q - 5'h0_1;
		end
	end

	// ----------------------------------------
	// watchdog and safety timer
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			host_q <= 1'b0;
			wd_exp_q <= 1'b1;
			wd_cyc_q <= 32'h0000_0000;
			wd_ms_q <= 32'h0000_0000;
		end else if (kick) begin
			host_q <= 1'b1;
			wd_exp_q <= 1'b0;
			wd_cyc_q <= 32'h0000_0000;
			wd_ms_q <= 32'h0000_0000;
		end else if (wd_expire) begin
			host_q <= 1'b0;
			wd_exp_q <= 1'b1;
		end else if (host_q && wdsel_q != 2'h0) begin
			if (wd_cyc_q >= MS_CYC - 1) begin
				wd_cyc_q <= 32'h0000_0000;
				wd_ms_q <= wd_ms_q + 32'h0000_0001;
			end else begin
				wd_cyc_q <= wd_cyc_q + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET || host_q || !CHARGE_ACTIVE) begin
			safe_cyc_q <= 32'h0000_0000;
			safe_ms_q <= 32'h0000_0000;
			if (RESET) safe_done_q <= 1'b0;
		end else if (safe_ms_q >= SAFE_MS) begin
			safe_done_q <= 1'b1;
		end else if (safe_cyc_q >= MS_CYC - 1) begin
			safe_cyc_q <= 32'h0000_0000;
			safe_ms_q <= safe_ms_q + 32'h0000_0001;
		end else begin
			safe_cyc_q <= safe_cyc_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET || wd_expire) begin
			chg_en_q <= 1'b1;
			ll_dis_q <= 1'b0;
			rev_en_q <= 1'b0;
			rev_lim_q <= 1'b1;
			det_req_q <= 1'b0;
			trk_q <= `CPSQ_TRK_RST;
			wdsel_q <= `CPSQ_WDSEL_RST;
			if (RESET) begin
				bsw_rsten_q <= 1'b1;
				bsw_dly_q <= 1'b0;
				vil_q <= `CPSQ_VIL_RST;
			end
		end else begin
			det_req_q <= 1'b0;
			if (bus_wr && WB_ADR_I == `CPSQ_ADDR_CTRL) begin
				chg_en_q <= WB_DAT_I[`CPSQ_CTRL_CHG_EN];
				ll_dis_q <= WB_DAT_I[`CPSQ_CTRL_LL_DIS];
				rev_en_q <= WB_DAT_I[`CPSQ_CTRL_REV_EN];
				rev_lim_q <= WB_DAT_I[`CPSQ_CTRL_REV_LIM];
				det_req_q <= WB_DAT_I[`CPSQ_CTRL_DET_REQ];
				bsw_rsten_q <= WB_DAT_I[`CPSQ_CTRL_BSW_RSTEN];
				bsw_dly_q <= WB_DAT_I[`CPSQ_CTRL_BSW_DLY];
			end
			if (bus_wr && WB_ADR_I == `CPSQ_ADDR_LIMIT) begin
				vil_q <= WB_DAT_I[8:5];
				trk_q <= WB_DAT_I[10:9];
			end
			if (bus_wr && WB_ADR_I == `CPSQ_ADDR_WDOG) begin
				wdsel_q <= WB_DAT_I[2:1];
			end
		end
	end

	// input current limit: kept across expiry
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			icl_q <= `CPSQ_ICL_RST;
		end else if (st_q == ST_DET || (!host_q && st_q == ST_CONV)
			|| (host_q && det_req_q)) begin
			icl_q <= pin_icl(SOURCE_SELECT);
		end else if (bus_wr && WB_ADR_I == `CPSQ_ADDR_LIMIT && host_q) begin
			icl_q <= WB_DAT_I[4:0];
		end
	end

	// battery switch off flag: overload set wins over clear
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			bsw_off_q <= 1'b0;
		end else if (BAT_OVERCURRENT && BATTERY_SWITCH_ON) begin
			bsw_off_q <= 1'b1;
		end else if (st_q == ST_BIAS || SHIP_EXIT) begin
			bsw_off_q <= 1'b0;
		end else if (bus_wr && WB_ADR_I == `CPSQ_ADDR_CTRL) begin
			bsw_off_q <= WB_DAT_I[`CPSQ_CTRL_BSW_OFF];
		end
	end

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
			WB_DAT_O <= 32'h0000_0000;
			if (bus_rd) begin
				case (WB_ADR_I)
					`CPSQ_ADDR_CTRL: WB_DAT_O <= {24'h00_0000, bsw_dly_q,
						bsw_rsten_q, bsw_off_q, 1'b0, rev_lim_q, rev_en_q,
						ll_dis_q, chg_en_q};
					`CPSQ_ADDR_LIMIT: WB_DAT_O <= {21'h00_0000, trk_q,
						vil_q, icl_q};
					`CPSQ_ADDR_STATUS: WB_DAT_O <= {23'h00_0000,
						safe_done_q, st_q == ST_REV, pg_q, in_good_q,
						src_q, host_q, wd_exp_q};
					`CPSQ_ADDR_WDOG: WB_DAT_O <= {29'h0000_0000, wdsel_q,
						1'b0};
					default: WB_DAT_O <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// power stage outputs
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			BATTERY_SWITCH_ON <= 1'b0;
			INTERNAL_BIAS_REGULATOR <= 1'b0;
			QUAL_LOAD_ON <= 1'b0;
			CONVERTER_ON <= 1'b0;
			REVERSE_MODE <= 1'b0;
			REVERSE_LIMIT_HIGH <= 1'b0;
			LIGHT_LOAD_ALLOW <= 1'b0;
			CHARGE_ACTIVE <= 1'b0;
			USE_TRACKED_VLIMIT <= 1'b0;
			EFFECTIVE_ICL <= `CPSQ_ICL_RST;
			HOST_EVENT_PULSE_N <= 1'b1;
		end else begin
			HOST_EVENT_PULSE_N <= pulse_q == 5'h0_0;
			if (BAT_OVERCURRENT && BATTERY_SWITCH_ON) begin
				BATTERY_SWITCH_ON <= 1'b0;
			end else if (st_q == ST_CONV) begin
				BATTERY_SWITCH_ON <= chg_en_q && !bsw_off_q;
			end else begin
				BATTERY_SWITCH_ON <= BAT_ABOVE_DEPLETION && !bsw_off_q;
			end
			INTERNAL_BIAS_REGULATOR <= st_q != ST_OFF;
			QUAL_LOAD_ON <= st_q == ST_QUAL;
			CONVERTER_ON <= st_q == ST_CONV;
			REVERSE_MODE <= st_q == ST_REV;
			REVERSE_LIMIT_HIGH <= rev_lim_q;
			LIGHT_LOAD_ALLOW <= !ll_dis_q && (st_q == ST_REV
				|| !chg_en_q || BAT_BELOW_MINSYS);
			CHARGE_ACTIVE <= st_q == ST_CONV && chg_en_q && !safe_done_q;
			USE_TRACKED_VLIMIT <= trk_q != 2'h0 && BAT_ABOVE_VIL;
			EFFECTIVE_ICL <= (SYS_BELOW_2V2 && icl_q > `CPSQ_ICL_200)
				? `CPSQ_ICL_200 : icl_q;
		end
	end

endmodule

`default_nettype wire

// ===== testbench/cpsq_seq_props.sv
`timescale 1ns/100ps
`default_nettype none

module cpsq_seq_props (
	// clock and reset
	input wire logic       CLOCK,
	input wire logic       RESET,
	// comparator levels
	input wire logic       BAT_OVERCURRENT,
	input wire logic       SHIP_EXIT,
	input wire logic       INPUT_PRESENT,
	input wire logic       INPUT_ABOVE_SLEEP,
	input wire logic       INPUT_BELOW_OV,
	input wire logic       INPUT_ABOVE_MIN,
	input wire logic       SYS_BELOW_2V2,
	input wire logic       BAT_ABOVE_LOW,
	input wire logic       INPUT_BELOW_BAT_SLEEP,
	input wire logic       THERMISTOR_INPUT_OK,
	// power stage outputs
	input wire logic       BATTERY_SWITCH_ON,
	input wire logic       INTERNAL_BIAS_REGULATOR,
	input wire logic       QUAL_LOAD_ON,
	input wire logic       CONVERTER_ON,
	input wire logic       REVERSE_MODE,
	input wire logic [4:0] EFFECTIVE_ICL,
	input wire logic       HOST_EVENT_PULSE_N
);
	logic [4:0] low_cnt_q;

	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);

	// consecutive low samples of the event output
	always_ff @(posedge CLOCK) begin
		if (RESET || HOST_EVENT_PULSE_N)
			low_cnt_q <= 5'h00;
		else if (low_cnt_q != 5'h1F)
			low_cnt_q <= low_cnt_q + 5'h01;
	end

	AST_EVENT_WIDTH: assert property (
		$rose(HOST_EVENT_PULSE_N) |-> low_cnt_q == 5'h10)
		else $error("event pulse too short");
	AST_EVENT_LONG: assert property (
		!HOST_EVENT_PULSE_N |-> low_cnt_q < 5'h10)
		else $error("event pulse too long");
	AST_BIAS_CAUSE: assert property (
		$rose(INTERNAL_BIAS_REGULATOR) && !REVERSE_MODE
		|-> $past(INPUT_PRESENT, 2) && $past(INPUT_ABOVE_SLEEP, 2))
		else $error("bias on without input");
	AST_QUAL_WINDOW: assert property (
		$rose(QUAL_LOAD_ON) ##0 (INPUT_BELOW_OV && INPUT_ABOVE_MIN)[*8]
		|-> QUAL_LOAD_ON && INTERNAL_BIAS_REGULATOR)
		else $error("qualification load dropped");
	AST_CONV_ORDER: assert property (
		$rose(CONVERTER_ON) |-> INTERNAL_BIAS_REGULATOR && !QUAL_LOAD_ON)
		else $error("converter out of order");
	AST_ICL_CAP: assert property (
		(CONVERTER_ON && SYS_BELOW_2V2)[*2] |-> EFFECTIVE_ICL <= 5'h01)
		else $error("current limit not capped");
	AST_OVERLOAD_CUT: assert property (
		BATTERY_SWITCH_ON && BAT_OVERCURRENT |=> !BATTERY_SWITCH_ON)
		else $error("switch not cut on overload");
	AST_STAY_OFF: assert property (
		$fell(BATTERY_SWITCH_ON) && $past(BAT_OVERCURRENT)
		##1 (!INPUT_PRESENT && !SHIP_EXIT)[*4] |-> !BATTERY_SWITCH_ON)
		else $error("switch back on after overload");
	AST_REV_GATE: assert property (
		$rose(REVERSE_MODE) |-> $past(BAT_ABOVE_LOW, 2)
		&& $past(INPUT_BELOW_BAT_SLEEP, 2) && $past(THERMISTOR_INPUT_OK, 2))
		else $error("reverse mode without conditions");

	cover property ($rose(CONVERTER_ON));
	cover property ($rose(REVERSE_MODE));
	cover property ($fell(HOST_EVENT_PULSE_N));
endmodule

`default_nettype wire

// ===== testbench/cpsq_src_model.sv
`timescale 1ns/100ps
`default_nettype none

module cpsq_src_model (
	// control from bench
	input  wire logic plug,
	input  wire logic healthy,
	// comparator levels seen by the sequencer
	output logic      present,
	output logic      above_sleep,
	output logic      below_ov,
	output logic      above_min,
	output logic      below_bat_sleep
);
	assign present = plug;
	assign above_sleep = plug;
	assign below_ov = 1'b1;
	assign above_min = plug && healthy;
	assign below_bat_sleep = !plug;
endmodule

`default_nettype wire

// ===== testbench/cpsq_seq_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpsq_params.svh"

module cpsq_seq_tb;
	import cpsq_pkg::*;

	logic        CLOCK, RESET, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
	logic [3:0]  WB_ADR_I, WB_SEL_I;
	logic [31:0] WB_DAT_I, WB_DAT_O, rd;
	logic        BAT_ABOVE_DEPLETION, BAT_OVERCURRENT, SHIP_EXIT;
	logic        SOURCE_SELECT, SYS_BELOW_2V2, BAT_BELOW_MINSYS;
	logic        BAT_ABOVE_LOW, THERMISTOR_INPUT_OK, BAT_ABOVE_VIL;
	wire logic   INPUT_PRESENT, INPUT_ABOVE_SLEEP, INPUT_BELOW_OV;
	wire logic   INPUT_ABOVE_MIN, INPUT_BELOW_BAT_SLEEP;
	logic        BATTERY_SWITCH_ON, INTERNAL_BIAS_REGULATOR, QUAL_LOAD_ON;
	logic        CONVERTER_ON, REVERSE_MODE, REVERSE_LIMIT_HIGH;
	logic        LIGHT_LOAD_ALLOW, CHARGE_ACTIVE, USE_TRACKED_VLIMIT;
	logic        HOST_EVENT_PULSE_N, plug, healthy;
	logic [4:0]  EFFECTIVE_ICL;
	int          errors, comparisons, cycles, n;

	cpsq_seq #(.BIAS_CYC(20), .QUAL_CYC(10), .RETRY_CYC(30), .REV_CYC(10),
		.MS_CYC(2), .SAFE_MS(50), .WD1_MS(20)) i_dut (.*);

	cpsq_src_model i_src (
		.plug           (plug),
		.healthy        (healthy),
		.present        (INPUT_PRESENT),
		.above_sleep    (INPUT_ABOVE_SLEEP),
		.below_ov       (INPUT_BELOW_OV),
		.above_min      (INPUT_ABOVE_MIN),
		.below_bat_sleep(INPUT_BELOW_BAT_SLEEP)
	);

	initial begin
		CLOCK = 1'b0;
		forever #25 CLOCK = ~CLOCK;
	end

	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			complete_run();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [3:0] a,
		input logic [31:0] d);
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= we;
		WB_ADR_I <= a;
		WB_SEL_I <= 4'hF;
		WB_DAT_I <= d;
		do @(posedge CLOCK); while (WB_ACK_O !== 1'b1);
		rd = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		WB_SEL_I <= 4'h0;
		@(posedge CLOCK);
	endtask

	task automatic pulse_check;
		n = 0;
		while (HOST_EVENT_PULSE_N !== 1'b0) @(posedge CLOCK);
		while (HOST_EVENT_PULSE_N === 1'b0) begin
			@(posedge CLOCK);
			n++;
		end
		check(n, 16);
	endtask

	task automatic reset_defaults;
		check(EFFECTIVE_ICL, `CPSQ_ICL_RST);
		wb(1'b0, `CPSQ_ADDR_STATUS, 32'h0000_0000);
		check(rd[1:0], 2'b01);
		wb(1'b0, `CPSQ_ADDR_LIMIT, 32'h0000_0000);
		check(rd[10:0], 11'h0C4);
		wb(1'b0, 4'h2, 32'h0000_0000);
		check(rd, 32'h0000_0000);
	endtask

	task automatic battery_only;
		BAT_ABOVE_DEPLETION <= 1'b1;
		repeat (3) @(posedge CLOCK);
		check({BATTERY_SWITCH_ON, INTERNAL_BIAS_REGULATOR}, 2'b10);
		BAT_OVERCURRENT <= 1'b1;
		@(posedge CLOCK);
		BAT_OVERCURRENT <= 1'b0;
		repeat (5) @(posedge CLOCK);
		check(BATTERY_SWITCH_ON, 1'b0);
		wb(1'b0, `CPSQ_ADDR_CTRL, 32'h0000_0000);
		check(rd[5], 1'b1);
		SHIP_EXIT <= 1'b1;
		@(posedge CLOCK);
		SHIP_EXIT <= 1'b0;
		repeat (3) @(posedge CLOCK);
		check(BATTERY_SWITCH_ON, 1'b1);
	endtask

	task automatic power_up;
		plug <= 1'b1;
		n = 0;
		while (INTERNAL_BIAS_REGULATOR !== 1'b1) begin
			@(posedge CLOCK);
			n++;
		end
		check(n >= 20, 1'b1);
		while (QUAL_LOAD_ON !== 1'b1) @(posedge CLOCK);
		repeat (15) @(posedge CLOCK);
		wb(1'b0, `CPSQ_ADDR_STATUS, 32'h0000_0000);
		check(rd[5], 1'b0);
		healthy <= 1'b1;
		pulse_check();
		wb(1'b0, `CPSQ_ADDR_STATUS, 32'h0000_0000);
		check(rd[5], 1'b1);
		pulse_check();
		wb(1'b0, `CPSQ_ADDR_STATUS, 32'h0000_0000);
		check(rd[6:2], {2'b11, `CPSQ_SRC_ADAPT});
		repeat (2) @(posedge CLOCK);
		check(CONVERTER_ON, 1'b1);
		check(EFFECTIVE_ICL, `CPSQ_ICL_2400);
		SYS_BELOW_2V2 <= 1'b1;
		repeat (3) @(posedge CLOCK);
		check(EFFECTIVE_ICL, `CPSQ_ICL_200);
		SYS_BELOW_2V2 <= 1'b0;
		SOURCE_SELECT <= 1'b1;
		repeat (3) @(posedge CLOCK);
		check(EFFECTIVE_ICL, `CPSQ_ICL_500);
		check(LIGHT_LOAD_ALLOW, 1'b0);
		BAT_BELOW_MINSYS <= 1'b1;
		repeat (2) @(posedge CLOCK);
		check(LIGHT_LOAD_ALLOW, 1'b1);
		BAT_BELOW_MINSYS <= 1'b0;
	endtask

	task automatic host_mode;
		wb(1'b1, `CPSQ_ADDR_WDOG, 32'h0000_0003);
		wb(1'b0, `CPSQ_ADDR_STATUS, 32'h0000_0000);
		check(rd[1:0], 2'b10);
		wb(1'b1, `CPSQ_ADDR_LIMIT, 32'h0000_00CA);
		SOURCE_SELECT <= 1'b0;
		BAT_ABOVE_VIL <= 1'b1;
		repeat (3) @(posedge CLOCK);
		check(EFFECTIVE_ICL, 5'h0A);
		check(USE_TRACKED_VLIMIT, 1'b0);
		wb(1'b1, `CPSQ_ADDR_LIMIT, 32'h0000_032A);
		check(USE_TRACKED_VLIMIT, 1'b1);
		wb(1'b1, `CPSQ_ADDR_CTRL, 32'h0000_0058);
		repeat (3) @(posedge CLOCK);
		check(EFFECTIVE_ICL, `CPSQ_ICL_2400);
		check(BATTERY_SWITCH_ON, 1'b0);
		repeat (60) @(posedge CLOCK);
		wb(1'b0, `CPSQ_ADDR_STATUS, 32'h0000_0000);
		check(rd[1:0], 2'b01);
		wb(1'b0, `CPSQ_ADDR_LIMIT, 32'h0000_0000);
		check(rd[10:0], 11'h137);
		check(USE_TRACKED_VLIMIT, 1'b0);
		check(CHARGE_ACTIVE, 1'b1);
		repeat (80) @(posedge CLOCK);
		check(CHARGE_ACTIVE, 1'b0);
		check(CONVERTER_ON, 1'b1);
	endtask

	task automatic reverse_supply;
		plug <= 1'b0;
		repeat (4) @(posedge CLOCK);
		wb(1'b1, `CPSQ_ADDR_WDOG, 32'h0000_0001);
		wb(1'b1, `CPSQ_ADDR_CTRL, 32'h0000_004D);
		n = 0;
		while (REVERSE_MODE !== 1'b1) begin
			@(posedge CLOCK);
			n++;
		end
		check(n >= 9, 1'b1);
		check(REVERSE_LIMIT_HIGH, 1'b1);
		check(LIGHT_LOAD_ALLOW, 1'b1);
		repeat (45) @(posedge CLOCK);
		wb(1'b0, `CPSQ_ADDR_STATUS, 32'h0000_0000);
		check(rd[4:2], `CPSQ_SRC_REV);
		check(rd[1:0], 2'b10);
		wb(1'b1, `CPSQ_ADDR_CTRL, 32'h0000_004F);
		check(LIGHT_LOAD_ALLOW, 1'b0);
		THERMISTOR_INPUT_OK <= 1'b0;
		repeat (3) @(posedge CLOCK);
		check(REVERSE_MODE, 1'b0);
	endtask

	task automatic complete_run;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		{WB_CYC_I, WB_STB_I, WB_WE_I, BAT_OVERCURRENT, SHIP_EXIT} = 5'h00;
		{SYS_BELOW_2V2, BAT_BELOW_MINSYS, BAT_ABOVE_VIL} = 3'h0;
		{BAT_ABOVE_DEPLETION, plug, healthy, SOURCE_SELECT} = 4'h0;
		{BAT_ABOVE_LOW, THERMISTOR_INPUT_OK} = 2'h3;
		{WB_ADR_I, WB_SEL_I} = 8'h00;
		WB_DAT_I = 32'h0000_0000;
		RESET = 1'b1;
		repeat (2) @(posedge CLOCK);
		RESET <= 1'b0;
		@(posedge CLOCK);
		reset_defaults();
		battery_only();
		power_up();
		host_mode();
		reverse_supply();
		complete_run();
	end
endmodule

bind cpsq_seq cpsq_seq_props i_props (.*);

`default_nettype wire
